// *** logic/pwm_rtp_pkg.sv ***
// constants, register map and shared functions for the waveform output group
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package pwm_rtp_pkg;

    localparam int unsigned CHANNELS = 8;
    localparam int unsigned TIMER_W  = 16;
    localparam int unsigned POS_W    = 6;
    localparam int unsigned SPAN_W   = 10;

    // register byte offsets
    localparam logic [7:0] OFS_BASE_TIMER_CONTROL  = 8'h00;
    localparam logic [7:0] OFS_FUNCTION_ENABLE     = 8'h04;
    localparam logic [7:0] OFS_PORT_OUTPUT_VALUE   = 8'h08;
    localparam logic [7:0] OFS_INTERRUPT_REQUEST   = 8'h0c;
    localparam logic [7:0] OFS_TIMER_COUNT         = 8'h10;
    localparam logic [7:0] OFS_COMPARE_BASE        = 8'h20;
    localparam logic [7:0] OFS_OUTPUT_CONTROL_BASE = 8'h40;
    localparam logic [7:0] OFS_BANK_MASK           = 8'he0;

    // field positions in channel_output_control
    localparam int unsigned FLD_INVERT  = 0;
    localparam int unsigned FLD_DEFAULT = 1;
    localparam int unsigned FLD_RTP     = 2;

    // timer_reset_select codes
    localparam logic [2:0] RST_SEL_FREE = 3'h0;
    localparam logic [2:0] RST_SEL_CMP0 = 3'h2;

    localparam logic [2:0]  RESET_SEL_INIT = 3'h0;
    localparam logic [7:0]  ENABLE_INIT    = 8'h00;
    localparam logic [7:0]  PORT_INIT      = 8'h00;
    localparam logic [15:0] COMPARE_INIT   = 16'h0000;
    localparam logic [2:0]  CONTROL_INIT   = 3'h0;

    // a span is lengthened when the modulation bit tied to its lowest set bit is on
    function automatic logic span_extended(input logic [9:0] span, input logic [9:0] m);
        logic hit;
        logic found;
        hit   = 1'b0;
        found = 1'b0;
        for (int i = 0; i < 10; i++)
        begin
            if (!found && span[i])
            begin
                found = 1'b1;
                hit   = m[9 - i];
            end
        end
        return hit;
    endfunction

    // merge the two low byte lanes of a bus write into a 16-bit register
    function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                               input logic [31:0] wdata,
                                               input logic [3:0]  be);
        logic [15:0] v;
        v = old_v;
        if (be[0])
        begin
            v[7:0] = wdata[7:0];
        end
        if (be[1])
        begin
            v[15:8] = wdata[15:8];
        end
        return v;
    endfunction

endpackage

// *** logic/timer_share_if.sv ***
// shared base timer signals between the timer, its control and the channels
interface timer_share_if;
    logic [15:0] count;
    logic [2:0]  reset_sel;
    logic [15:0] clear_cmp;

    modport timer (output count, input reset_sel, input clear_cmp);
    modport ctrl  (output reset_sel, output clear_cmp, input count);
    modport chan  (input count);
endinterface

// *** logic/base_timer_unit.sv ***
// 16-bit base timer with optional clear on channel-0 compare match
module base_timer_unit
(
    input  wire logic    clk_in,
    input  wire logic    rst_n_in,
    timer_share_if.timer tb
);

    logic [15:0] count_r;
    logic [15:0] count_nxt;

    always_comb
    begin
        count_nxt = count_r + 16'h0001;
        if (tb.reset_sel == pwm_rtp_pkg::RST_SEL_CMP0 && count_r == tb.clear_cmp)
        begin
            count_nxt = 16'h0000;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            count_r <= 16'h0000;
        end
        else
        begin
            count_r <= count_nxt;
        end
    end

    assign tb.count = count_r;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    sequence free_tick;
        tb.reset_sel == pwm_rtp_pkg::RST_SEL_FREE;
    endsequence

    chk_timer_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (tb.reset_sel == pwm_rtp_pkg::RST_SEL_CMP0 && count_r == tb.clear_cmp)
        |=> count_r == 16'h0000)
        else $error("base timer not cleared on channel-0 match");

    chk_timer_free: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        free_tick |=> count_r == 16'($past(count_r) + 16'h0001))
        else $error("free-running base timer did not advance by one");

endmodule

// *** logic/wave_channel.sv ***
// one waveform channel: bit-modulation pwm or one-bit real-time port output
module wave_channel
(
    input  wire logic    clk_in,
    input  wire logic    rst_n_in,
    timer_share_if.chan  tb,
    input  wire logic    enable_in,
    input  wire logic    rtp_mode_in,
    input  wire logic    invert_in,
    input  wire logic    default_level_in,
    input  wire logic    port_bit_in,
    input  wire logic [15:0] compare_in,
    output logic         pin_out,
    output logic         drive_out,
    output logic         match_out
);

    logic       level_r;
    logic       level_nxt;
    logic       pin_r;
    logic       pin_nxt;
    logic [5:0] pos;
    logic [9:0] span;
    logic [5:0] base_w;
    logic       ext;
    logic [6:0] low_w;

    assign pos    = tb.count[5:0];
    assign span   = tb.count[15:6];
    assign base_w = compare_in[15:10];
    assign ext    = pwm_rtp_pkg::span_extended(span, compare_in[9:0]);
    assign low_w  = {1'b0, base_w} + {6'h00, ext};

    always_comb
    begin
        match_out = 1'b0;
        level_nxt = level_r;
        if (!enable_in)
        begin
            level_nxt = default_level_in;
        end
        else if (rtp_mode_in)
        begin
            match_out = (tb.count == compare_in);
            if (match_out)
            begin
                level_nxt = port_bit_in;
            end
        end
        else
        begin
            match_out = (pos == base_w);
            if ({1'b0, pos} == low_w)
            begin
                level_nxt = 1'b1;
            end
            else if (pos == 6'h00)
            begin
                level_nxt = 1'b0;
            end
        end
        pin_nxt = level_nxt ^ invert_in;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            level_r <= 1'b0;
            pin_r   <= 1'b0;
        end
        else
        begin
            level_r <= level_nxt;
            pin_r   <= pin_nxt;
        end
    end

    assign pin_out   = pin_r;
    assign drive_out = enable_in;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence pwm_on;
        enable_in && !rtp_mode_in;
    endsequence

    chk_span_start: assert property (
        pwm_on ##0 (pos == 6'h00 && low_w != 7'h00) |=> !level_r)
        else $error("span did not start low");

    chk_span_extend: assert property (
        pwm_on ##0 (ext && pos == base_w && base_w != 6'h3f) |=> !level_r)
        else $error("lengthened span went high too early");

    chk_rtp_copy: assert property (
        (enable_in && rtp_mode_in && tb.count == compare_in) |=> level_r == $past(port_bit_in))
        else $error("port bit not copied on match");

    chk_pin_invert: assert property (
        1'b1 |=> pin_r == (level_r ^ $past(invert_in)))
        else $error("pin does not follow level and invert bit");

    chk_idle_default: assert property (
        !enable_in |=> level_r == $past(default_level_in))
        else $error("idle channel not at default level");

endmodule

// *** logic/bitmod_pwm_rtp_output.sv ***
// eight-channel bit-modulation pwm / real-time port output group with avalon-mm registers
module bitmod_pwm_rtp_output
(
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RST_N_IN,
    input  wire logic [7:0]  AVS_ADDRESS_IN,
    input  wire logic        AVS_READ_IN,
    input  wire logic        AVS_WRITE_IN,
    input  wire logic [31:0] AVS_WRITEDATA_IN,
    input  wire logic [3:0]  AVS_BYTEENABLE_IN,
    output logic      [31:0] AVS_READDATA_OUT,
    output logic             AVS_WAITREQUEST_OUT,
    output logic      [7:0]  CHANNEL_WAVEFORM_PIN_OUT,
    output logic      [7:0]  CHANNEL_WAVEFORM_OE_OUT
);

    // -----------------------------------------------------------------
    // bus handshake state
    // -----------------------------------------------------------------
    typedef enum logic [0:0] {BUS_IDLE, BUS_ACK} bus_state_e;

    bus_state_e  bus_state_r;
    bus_state_e  bus_state_nxt;
    logic [31:0] readdata_r;
    logic [31:0] readdata_nxt;
    logic        req;
    logic        commit_wr;

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    logic [2:0]  reset_sel_r;
    logic [2:0]  reset_sel_nxt;
    logic [7:0]  enable_r;
    logic [7:0]  enable_nxt;
    logic [7:0]  port_r;
    logic [7:0]  port_nxt;
    logic [7:0]  flag_r;
    logic [7:0]  flag_nxt;
    logic [15:0] compare_r [8];
    logic [15:0] compare_nxt [8];
    logic [2:0]  control_r [8];
    logic [2:0]  control_nxt [8];

    logic [7:0]  match;
    logic [7:0]  flag_clr;
    logic [2:0]  addr_idx;
    logic        in_cmp_bank;
    logic        in_ctl_bank;

    timer_share_if tshare ();

    assign req         = AVS_READ_IN || AVS_WRITE_IN;
    assign commit_wr   = AVS_WRITE_IN && (bus_state_r == BUS_ACK);
    assign addr_idx    = AVS_ADDRESS_IN[4:2];
    assign in_cmp_bank = (AVS_ADDRESS_IN & pwm_rtp_pkg::OFS_BANK_MASK)
                         == pwm_rtp_pkg::OFS_COMPARE_BASE;
    assign in_ctl_bank = (AVS_ADDRESS_IN & pwm_rtp_pkg::OFS_BANK_MASK)
                         == pwm_rtp_pkg::OFS_OUTPUT_CONTROL_BASE;

    // the request is held for exactly one extra cycle so every access answers alike
    assign AVS_WAITREQUEST_OUT = req && (bus_state_r == BUS_IDLE);
    assign AVS_READDATA_OUT    = readdata_r;

    always_comb
    begin
        bus_state_nxt = BUS_IDLE;
        readdata_nxt  = readdata_r;
        case (bus_state_r)
            BUS_IDLE:
            begin
                if (req)
                begin
                    bus_state_nxt = BUS_ACK;
                end
                if (AVS_READ_IN)
                begin
                    readdata_nxt = 32'h0000_0000;
                    if (in_cmp_bank)
                    begin
                        readdata_nxt = {16'h0000, compare_r[addr_idx]};
                    end
                    else if (in_ctl_bank)
                    begin
                        readdata_nxt = {29'h0000_0000, control_r[addr_idx]};
                    end
                    else
                    begin
                        case (AVS_ADDRESS_IN)
                            pwm_rtp_pkg::OFS_BASE_TIMER_CONTROL:
                                readdata_nxt = {29'h0000_0000, reset_sel_r};
                            pwm_rtp_pkg::OFS_FUNCTION_ENABLE:
                                readdata_nxt = {24'h00_0000, enable_r};
                            pwm_rtp_pkg::OFS_PORT_OUTPUT_VALUE:
                                readdata_nxt = {24'h00_0000, port_r};
                            pwm_rtp_pkg::OFS_INTERRUPT_REQUEST:
                                readdata_nxt = {24'h00_0000, flag_r};
                            pwm_rtp_pkg::OFS_TIMER_COUNT:
                                readdata_nxt = {16'h0000, tshare.count};
                            default:
                                readdata_nxt = 32'h0000_0000;
                        endcase
                    end
                end
            end
            BUS_ACK:
            begin
                bus_state_nxt = BUS_IDLE;
            end
            default:
            begin
                bus_state_nxt = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            bus_state_r <= BUS_IDLE;
            readdata_r  <= 32'h0000_0000;
        end
        else
        begin
            bus_state_r <= bus_state_nxt;
            readdata_r  <= readdata_nxt;
        end
    end

    // -----------------------------------------------------------------
    // register writes and request flags
    // -----------------------------------------------------------------
    always_comb
    begin
        reset_sel_nxt = reset_sel_r;
        enable_nxt    = enable_r;
        port_nxt      = port_r;
        flag_clr      = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            compare_nxt[i] = compare_r[i];
            control_nxt[i] = control_r[i];
        end
        if (commit_wr && AVS_BYTEENABLE_IN[0])
        begin
            if (in_cmp_bank)
            begin
                compare_nxt[addr_idx] = pwm_rtp_pkg::lane_merge(compare_r[addr_idx],
                                                               AVS_WRITEDATA_IN,
                                                               AVS_BYTEENABLE_IN);
            end
            else if (in_ctl_bank)
            begin
                control_nxt[addr_idx] = AVS_WRITEDATA_IN[2:0];
            end
            else
            begin
                case (AVS_ADDRESS_IN)
                    pwm_rtp_pkg::OFS_BASE_TIMER_CONTROL:
                        reset_sel_nxt = AVS_WRITEDATA_IN[2:0];
                    pwm_rtp_pkg::OFS_FUNCTION_ENABLE:
                        enable_nxt = AVS_WRITEDATA_IN[7:0];
                    pwm_rtp_pkg::OFS_PORT_OUTPUT_VALUE:
                        port_nxt = AVS_WRITEDATA_IN[7:0];
                    pwm_rtp_pkg::OFS_INTERRUPT_REQUEST:
                        flag_clr = AVS_WRITEDATA_IN[7:0];
                    default:
                        flag_clr = 8'h00;
                endcase
            end
        end
        else if (commit_wr && in_cmp_bank && AVS_BYTEENABLE_IN[1])
        begin
            compare_nxt[addr_idx] = pwm_rtp_pkg::lane_merge(compare_r[addr_idx],
                                                           AVS_WRITEDATA_IN,
                                                           AVS_BYTEENABLE_IN);
        end
        // a match in the clearing cycle keeps its flag
        flag_nxt = (flag_r & ~flag_clr) | match;
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            reset_sel_r <= pwm_rtp_pkg::RESET_SEL_INIT;
            enable_r    <= pwm_rtp_pkg::ENABLE_INIT;
            port_r      <= pwm_rtp_pkg::PORT_INIT;
            flag_r      <= 8'h00;
            for (int i = 0; i < 8; i++)
            begin
                compare_r[i] <= pwm_rtp_pkg::COMPARE_INIT;
                control_r[i] <= pwm_rtp_pkg::CONTROL_INIT;
            end
        end
        else
        begin
            reset_sel_r <= reset_sel_nxt;
            enable_r    <= enable_nxt;
            port_r      <= port_nxt;
            flag_r      <= flag_nxt;
            for (int i = 0; i < 8; i++)
            begin
                compare_r[i] <= compare_nxt[i];
                control_r[i] <= control_nxt[i];
            end
        end
    end

    // -----------------------------------------------------------------
    // base timer and channels
    // -----------------------------------------------------------------
    // only code 010b clears the timer; every other code runs free, which is what
    // pwm needs and what software is expected to choose for it
    assign tshare.reset_sel = reset_sel_r;
    assign tshare.clear_cmp = compare_r[0];

    base_timer_unit u_timer
    (
        .clk_in   (SYS_CLK_IN),
        .rst_n_in (RST_N_IN),
        .tb       (tshare)
    );

    for (genvar j = 0; j < 8; j++)
    begin : g_chan
        wave_channel u_chan
        (
            .clk_in           (SYS_CLK_IN),
            .rst_n_in         (RST_N_IN),
            .tb               (tshare),
            .enable_in        (enable_r[j]),
            .rtp_mode_in      (control_r[j][pwm_rtp_pkg::FLD_RTP]),
            .invert_in        (control_r[j][pwm_rtp_pkg::FLD_INVERT]),
            .default_level_in (control_r[j][pwm_rtp_pkg::FLD_DEFAULT]),
            .port_bit_in      (port_r[j]),
            .compare_in       (compare_r[j]),
            .pin_out          (CHANNEL_WAVEFORM_PIN_OUT[j]),
            .drive_out        (CHANNEL_WAVEFORM_OE_OUT[j]),
            .match_out        (match[j])
        );
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    sequence bus_wait;
        req && AVS_WAITREQUEST_OUT;
    endsequence

    chk_bus_answer: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        bus_wait |=> !AVS_WAITREQUEST_OUT)
        else $error("bus request not answered after one wait cycle");

    chk_flag_set: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        (match[0] && enable_r[0]) |=> flag_r[0])
        else $error("channel 0 match did not raise its flag");

    chk_enable_drive: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        (commit_wr && AVS_ADDRESS_IN == pwm_rtp_pkg::OFS_FUNCTION_ENABLE
         && AVS_BYTEENABLE_IN[0] && AVS_WRITEDATA_IN[0])
        |=> CHANNEL_WAVEFORM_OE_OUT[0])
        else $error("enable write did not start channel 0");

    // goes through the write path, so it does not hold merely because oe mirrors the enable bit
    chk_disable_stop: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        (commit_wr && AVS_ADDRESS_IN == pwm_rtp_pkg::OFS_FUNCTION_ENABLE
         && AVS_BYTEENABLE_IN[0] && !AVS_WRITEDATA_IN[1])
        |=> !CHANNEL_WAVEFORM_OE_OUT[1])
        else $error("disable write did not stop channel 1");

    // a flag stays set until software writes a one to it
    sequence flag1_cleared;
        commit_wr && AVS_ADDRESS_IN == pwm_rtp_pkg::OFS_INTERRUPT_REQUEST
        && AVS_BYTEENABLE_IN[0] && AVS_WRITEDATA_IN[1];
    endsequence

    chk_flag_clear: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        flag1_cleared ##0 !match[1] |=> !flag_r[1])
        else $error("write-one did not clear channel 1 flag");

    chk_flag_sticky: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        (flag_r[1] && !(commit_wr && AVS_ADDRESS_IN == pwm_rtp_pkg::OFS_INTERRUPT_REQUEST))
        |=> flag_r[1])
        else $error("channel 1 flag dropped without a clear");

    chk_rtp_flag: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        (match[1] && enable_r[1]) |=> flag_r[1])
        else $error("channel 1 match did not raise its flag");

    chk_quiet_flag: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        (!enable_r[3] && !flag_r[3]) |=> !flag_r[3])
        else $error("disabled channel 3 raised its flag");

    sequence port_written;
        commit_wr && AVS_ADDRESS_IN == pwm_rtp_pkg::OFS_PORT_OUTPUT_VALUE
        && AVS_BYTEENABLE_IN[0];
    endsequence

    chk_port_write: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        port_written |=> port_r == $past(AVS_WRITEDATA_IN[7:0]))
        else $error("port output value write did not land");

    sequence enable_read;
        AVS_READ_IN && AVS_WAITREQUEST_OUT
        && AVS_ADDRESS_IN == pwm_rtp_pkg::OFS_FUNCTION_ENABLE;
    endsequence

    chk_read_data: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        enable_read |=> AVS_READDATA_OUT == {24'h00_0000, $past(enable_r)})
        else $error("enable register read returned wrong data");

endmodule

// *** bench/testbench.sv ***
// self-checking bench for the eight-channel pwm / real-time port output group
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // stimulus signals and the block under test
    // ------------------------------------------------------------
    logic        clk   = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  addr  = 8'h00;
    logic        rd    = 1'b0;
    logic        wr    = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic        waitreq;
    logic [7:0]  pins;
    logic [7:0]  oe;
    logic [31:0] q;
    int          mismatches      = 0;
    int          samples_checked = 0;

    bitmod_pwm_rtp_output bitmod_pwm_rtp_output_inst
    (
        .SYS_CLK_IN               (clk),
        .RST_N_IN                 (rst_n),
        .AVS_ADDRESS_IN           (addr),
        .AVS_READ_IN              (rd),
        .AVS_WRITE_IN             (wr),
        .AVS_WRITEDATA_IN         (wdata),
        .AVS_BYTEENABLE_IN        (4'hf),
        .AVS_READDATA_OUT         (rdata),
        .AVS_WAITREQUEST_OUT      (waitreq),
        .CHANNEL_WAVEFORM_PIN_OUT (pins),
        .CHANNEL_WAVEFORM_OE_OUT  (oe)
    );

    always #10 clk = ~clk;

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // one avalon transfer; the request is held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= w;
        rd    <= !w;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (waitreq !== 1'b0 && n < 20);
        check(waitreq, 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        logic [7:0] a [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h3c, 8'h5c, 8'hfc};
        check({oe, pins}, 16'h0);
        foreach (a[i])
        begin
            bus(1'b0, a[i], 32'h0);
            check(q, 32'h0);
        end
        $display("reset values done");
    endtask

    // timer must never pass the channel-0 compare while clear-on-match is on
    task automatic t_clear;
        bus(1'b1, 8'h20, 32'h100);
        bus(1'b1, 8'h00, 32'h2);
        repeat (5)
        begin
            cyc(90);
            bus(1'b0, 8'h10, 32'h0);
            check(q <= 32'h100, 1'b1);
        end
        bus(1'b1, 8'h00, 32'h0);
        cyc(300);
        bus(1'b0, 8'h10, 32'h0);
        check(q > 32'h100, 1'b1);
        $display("timer clear done");
    endtask

    task automatic t_rtp;
        logic [31:0] t;
        bus(1'b0, 8'h10, 32'h0);
        t = q + 32'd300;
        bus(1'b1, 8'h24, t);
        bus(1'b1, 8'h28, t);
        bus(1'b1, 8'h44, 32'h4);
        bus(1'b1, 8'h48, 32'h5);
        bus(1'b1, 8'h4c, 32'h2);
        bus(1'b1, 8'h08, 32'h6);
        bus(1'b1, 8'h04, 32'h6);
        cyc(2);
        check({oe[3:1], pins[3:1]}, 6'b011_110);
        cyc(300);
        check(pins[3:1], 3'b101);
        bus(1'b0, 8'h0c, 32'h0);
        check(q, 32'h6);
        bus(1'b1, 8'h0c, 32'h6);
        bus(1'b0, 8'h0c, 32'h0);
        check(q, 32'h0);
        bus(1'b1, 8'h04, 32'h0);
        cyc(2);
        check({oe, pins[2:1]}, 10'b0000_0000_10);
        $display("port output done");
    endtask

    // one whole period on four pwm channels; every low run is measured
    task automatic t_pwm;
        logic [15:0] cmp [4] = '{16'h1401, 16'h1402, 16'h1600, 16'h2bff};
        int          st [4];
        int          low [4];
        logic [7:0]  prev;
        int          est;
        int          s;
        int          n;
        logic        ext;
        for (int c = 0; c < 4; c++)
        begin
            bus(1'b1, 8'h30 + 8'(4 * c), {16'h0, cmp[c]});
            bus(1'b1, 8'h50 + 8'(4 * c), 32'h0);
            low[c] = 0;
        end
        // channel 0 runs as well so its flag and enable paths see traffic
        bus(1'b1, 8'h04, 32'hf1);
        bus(1'b0, 8'h10, 32'h0);
        est = int'(q[15:0]) + 1;
        n = 0;
        // start mid-span where every enabled channel is high, after one full span of events
        while (n < 64 || est % 64 != 40)
        begin
            @(posedge clk);
            est++;
            n++;
        end
        prev = pins;
        check(prev[7:4], 4'hf);
        for (int k = 0; k < 65536; k++)
        begin
            @(posedge clk);
            est++;
            for (int c = 0; c < 4; c++)
            begin
                low[c] += int'(!pins[c + 4]);
                if (prev[c + 4] && !pins[c + 4])
                begin
                    st[c] = est;
                end
                if (!prev[c + 4] && pins[c + 4])
                begin
                    s = ((st[c] + 8) / 64) % 1024;
                    ext = (c == 0) ? (s == 512) : (c == 1) ? (s % 512 == 256) :
                          (c == 2) ? s[0] : (s != 0);
                    n = est - st[c];
                    check(n, int'(cmp[c][15:10]) + ext);
                end
            end
            prev = pins;
        end
        for (int c = 0; c < 4; c++)
        begin
            s = int'(cmp[c][15:10]) * 1024 + int'(cmp[c][9:0]);
            check(low[c], s);
        end
        bus(1'b1, 8'h0c, 32'hff);
        cyc(70);
        bus(1'b0, 8'h0c, 32'h0);
        check(q, 32'hf1);
        bus(1'b1, 8'h50, 32'h2);
        bus(1'b1, 8'h04, 32'he1);
        cyc(2);
        check({oe[7:4], pins[4]}, 5'b1110_1);
        $display("bit modulation done");
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_clear;
        t_rtp;
        t_pwm;
        stop_test;
    end

    // the pwm period alone takes 65536 cycles, the rest under 1500
    initial
    begin
        repeat (90000) @(posedge clk);
        mismatches++;
        stop_test;
    end
endmodule
